// file: pet_top.sv
// Practice-mode timing-error logic: event timer, calculated-time counter,
// error, split capture and auxiliary display routing.
// Assumes front-panel switches are asynchronous and the odometer and
// calculated-time advance come from elsewhere as same-clock pulses.
//
// Contract
// - Power-up with shift and minus-ones toggles practice.
// - Practice replaces clock with twelve-hour event timer.
// - Practice replaces calc time with counter from zero.
// - First hour shows as zero, not twelve.
// - Error routed to aux on time selector at rotary adjust, next speed, calc time or odometer.
// - Aux error magnitude equals driver error magnitude, except while a split freezes the aux copy.
// - Practice hides auxiliary calc time from aux.
// - Without practice, error only when split, next speed.
// - In practice, reset while viewing error clears timers and odometer.
// - Held reset keeps timers and odometer at zero until release.
// - Split captures distance, elapsed and perfect time.
`timescale 1ns/1ps
`default_nettype none
module pet_top #(
  parameter int unsigned TICK     = pet_pkg::TICK_CYCLES,
  parameter int unsigned DEBOUNCE = pet_pkg::DEB_CYCLES,
  parameter int          ODO_W    = 20
) (
  // Clock and reset.
  input  wire logic                      ref_clk,
  input  wire logic                      reset_n,
  // Front-panel switches, asynchronous.
  input  wire logic                      shift_sw,
  input  wire logic                      ones_minus_sw,
  input  wire logic                      reset_sw,
  input  wire logic                      split_sw,
  input  wire logic                      time_sel_sw,
  input  wire logic [2:0]                rotary_sw,
  // Same-clock events from the rest of the computer.
  input  wire logic                      power_up,
  input  wire logic                      practice_saved,
  input  wire logic                      calc_tick,
  input  wire logic                      odo_pulse,
  input  wire logic                      hundredths_mode,
  // Mode state, for the nonvolatile store.
  output logic                           practice_mode,
  // Counters.
  output logic [pet_pkg::CNT_W-1:0]      event_timer,
  output logic [pet_pkg::CNT_W-1:0]      calc_counter,
  output logic [ODO_W-1:0]               odometer,
  output logic                           show_zero_hour,
  output logic                           max_alt_format,
  // Error, live to the driver and routed to the main auxiliary display.
  output logic                           err_late,
  output logic [pet_pkg::CNT_W-1:0]      err_live,
  output logic [pet_pkg::CNT_W-1:0]      aux_err,
  output logic [1:0]                     aux_src,
  // Split captures.
  output logic                           split_held,
  output logic [ODO_W-1:0]               split_dist,
  output logic [pet_pkg::CNT_W-1:0]      split_elapsed,
  output logic [pet_pkg::CNT_W-1:0]      split_perfect
);
  logic                       rs1_ff;
  logic                       rst_ff;
  logic [23:0]                div_ff;
  logic                       tick_ff;
  logic                       split_d_ff;
  logic                       pwr_done_ff;
  wire                        sh_s;
  wire                        om_s;
  wire                        rs_s;
  wire                        sp_s;
  wire                        ts_s;
  logic [2:0]                 r1_ff;
  logic [2:0]                 r2_ff;
  logic [2:0]                 r3_ff;
  logic [2:0]                 rot_ff;
  wire  [ODO_W-1:0]           nxt_odometer;
  wire  [pet_pkg::CNT_W-1:0]  et_w;
  wire  [pet_pkg::CNT_W-1:0]  ct_w;

  // Reset release through two flip-flops.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rs1_ff <= 1'b0;
      rst_ff <= 1'b0;
    end else begin
      rs1_ff <= 1'b1;
      rst_ff <= rs1_ff;
    end
  end

  // Debounced switch levels. Each toggle switch gets its own synchroniser so
  // contact bounce on one never disturbs the others.
  pet_sync #(
    .DEB    (DEBOUNCE)
  ) u_sh (
    .clk    (ref_clk),
    .rst_n  (rst_ff),
    .sw_in  (shift_sw),
    .sw_out (sh_s)
  );
  pet_sync #(
    .DEB    (DEBOUNCE)
  ) u_om (
    .clk    (ref_clk),
    .rst_n  (rst_ff),
    .sw_in  (ones_minus_sw),
    .sw_out (om_s)
  );
  pet_sync #(
    .DEB    (DEBOUNCE)
  ) u_rs (
    .clk    (ref_clk),
    .rst_n  (rst_ff),
    .sw_in  (reset_sw),
    .sw_out (rs_s)
  );
  pet_sync #(
    .DEB    (DEBOUNCE)
  ) u_sp (
    .clk    (ref_clk),
    .rst_n  (rst_ff),
    .sw_in  (split_sw),
    .sw_out (sp_s)
  );
  pet_sync #(
    .DEB    (DEBOUNCE)
  ) u_ts (
    .clk    (ref_clk),
    .rst_n  (rst_ff),
    .sw_in  (time_sel_sw),
    .sw_out (ts_s)
  );

  // Rotary code passes two plain flip-flops, then must read the same on two
  // samples before it is used. A code caught between positions could select
  // the error view for a cycle and let a held reset clear the counters.
  always_ff @(posedge ref_clk or negedge rst_ff) begin
    if (!rst_ff) begin
      r1_ff  <= 3'h0;
      r2_ff  <= 3'h0;
      r3_ff  <= 3'h0;
      rot_ff <= 3'h0;
    end else begin
      r1_ff <= rotary_sw;
      r2_ff <= r1_ff;
      r3_ff <= r2_ff;
      if (r2_ff == r3_ff) begin
        rot_ff <= r3_ff;
      end
    end
  end

  // True when the settled rotary code names the given position.
  function automatic logic rot_is(input logic [2:0] code, input pet_pkg::pet_rot_t pos);
    return code == 3'(pos);
  endfunction

  // Display decode.
  wire rot_adj  = rot_is(rot_ff, pet_pkg::PET_ROT_ADJUST);
  wire rot_next = rot_is(rot_ff, pet_pkg::PET_ROT_NEXT_SPEED);
  wire rot_calc = rot_is(rot_ff, pet_pkg::PET_ROT_CALC_TIME);
  wire rot_odo  = rot_is(rot_ff, pet_pkg::PET_ROT_ODOMETER);
  wire rot_err  = rot_adj | rot_next | rot_calc | rot_odo;
  wire view_err = practice_mode ? (ts_s & rot_err)
                                : (ts_s & rot_next & split_held);
  // Reset clears only while the error is being viewed, held until release.
  wire hold_zero = practice_mode & rs_s & view_err;
  wire split_rise = sp_s & ~split_d_ff;

  // Tenth-second tick divider.
  always_ff @(posedge ref_clk or negedge rst_ff) begin
    if (!rst_ff) begin
      div_ff  <= 24'h00_0000;
      tick_ff <= 1'b0;
    end else if (div_ff >= 24'(TICK - 1)) begin
      div_ff  <= 24'h00_0000;
      tick_ff <= 1'b1;
    end else begin
      div_ff  <= div_ff + 24'h00_0001;
      tick_ff <= 1'b0;
    end
  end

  // Event timer and calculated-time counter; both wrap at twelve hours.
  pet_cnt u_et (
    .clk   (ref_clk),
    .rst_n (rst_ff),
    .tick  (tick_ff),
    .run   (practice_mode),
    .clear (hold_zero),
    .count (et_w)
  );
  pet_cnt u_ct (
    .clk   (ref_clk),
    .rst_n (rst_ff),
    .tick  (calc_tick),
    .run   (practice_mode),
    .clear (hold_zero),
    .count (ct_w)
  );

  // Practice flag toggles once per power-up if both switches are held.
  always_ff @(posedge ref_clk or negedge rst_ff) begin
    if (!rst_ff) begin
      practice_mode <= pet_pkg::PRACTICE_RST;
      pwr_done_ff   <= 1'b0;
    end else if (power_up && !pwr_done_ff) begin
      pwr_done_ff   <= 1'b1;
      practice_mode <= (sh_s && om_s) ? ~practice_saved : practice_saved;
    end
  end

  // Error magnitude, shared by driver and auxiliary views, and sign for the driver only.
  function automatic logic [pet_pkg::CNT_W-1:0] abs_gap(
    input logic [pet_pkg::CNT_W-1:0] a,
    input logic [pet_pkg::CNT_W-1:0] b
  );
    return (a > b) ? (a - b) : (b - a);
  endfunction
  wire                       late_w = (et_w > ct_w);
  wire [pet_pkg::CNT_W-1:0]  mag_w  = abs_gap(et_w, ct_w);

  // Counter mirrors and display flags, one register stage behind the counters.
  always_ff @(posedge ref_clk or negedge rst_ff) begin
    if (!rst_ff) begin
      event_timer    <= '0;
      calc_counter   <= '0;
      show_zero_hour <= 1'b0;
      max_alt_format <= 1'b0;
    end else begin
      event_timer    <= et_w;
      calc_counter   <= ct_w;
      show_zero_hour <= practice_mode;
      max_alt_format <= practice_mode & hundredths_mode;
    end
  end

  // Live error for the driver's display; a split never freezes it.
  always_ff @(posedge ref_clk or negedge rst_ff) begin
    if (!rst_ff) begin
      err_late <= 1'b0;
      err_live <= '0;
    end else begin
      err_late <= late_w;
      err_live <= mag_w;
    end
  end

  // Odometer; a held reset wins over a count pulse in the same cycle.
  assign nxt_odometer = hold_zero ? '0
                      : (odo_pulse ? odometer + 1'b1 : odometer);
  always_ff @(posedge ref_clk or negedge rst_ff) begin
    if (!rst_ff) begin
      odometer <= '0;
    end else begin
      odometer <= nxt_odometer;
    end
  end

  // Split captures. The distance is taken from the odometer's next value, while
  // the counter values are taken as they stand before the same edge; a pulse
  // landing on the split edge is then in the distance but not in the two times.
  always_ff @(posedge ref_clk or negedge rst_ff) begin
    if (!rst_ff) begin
      split_held    <= 1'b0;
      split_d_ff    <= 1'b0;
      split_dist    <= '0;
      split_elapsed <= '0;
      split_perfect <= '0;
    end else begin
      split_d_ff <= sp_s;
      if (split_rise) begin
        split_held    <= ~split_held;
        split_dist    <= nxt_odometer;
        split_elapsed <= et_w;
        split_perfect <= ct_w;
      end
    end
  end

  // The auxiliary error follows the live error until a split freezes it; the
  // edge that starts or ends a split loads the live value.
  wire aux_frozen = split_held & ~split_rise;
  always_ff @(posedge ref_clk or negedge rst_ff) begin
    if (!rst_ff) begin
      aux_err <= '0;
    end else if (!aux_frozen) begin
      aux_err <= mag_w;
    end
  end

  // Practice mode gives the aux position to the error, never aux calc time.
  always_ff @(posedge ref_clk or negedge rst_ff) begin
    if (!rst_ff) begin
      aux_src <= 2'h0;
    end else if (view_err) begin
      aux_src <= 2'(pet_pkg::PET_AUX_ERROR);
    end else if (ts_s && !practice_mode) begin
      aux_src <= 2'(pet_pkg::PET_AUX_AUX_CALC);
    end else begin
      aux_src <= 2'(pet_pkg::PET_AUX_NORMAL);
    end
  end
endmodule
`default_nettype wire

// file: pet_pkg.sv
// Package for the practice-mode timing-error block.
// Assumes a 25 MHz core clock; both counters count in tenth-second ticks, the debounce in cycles.
package pet_pkg;
  // Core clock rate and the tenth-second tick derived from it.
  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned TICK_MS       = 100;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  // Twelve hours in tenth-second ticks, the wrap point of both counters.
  localparam int unsigned TWELVE_H_TICKS = 12 * 3600 * 10;
  localparam int          CNT_W         = 19;
  // One hour in tenth-second ticks; the zero-hour flag does not use it.
  localparam int unsigned HOUR_TICKS    = 36000;
  // Value of the practice-mode flag after reset.
  localparam logic        PRACTICE_RST  = 1'b0;
  // Switch debounce time in milliseconds and in cycles.
  localparam int unsigned DEB_MS        = 20;
  localparam int unsigned DEB_CYCLES    = CLK_HZ / 1000 * DEB_MS;
  // Rotary switch positions.
  typedef enum logic [2:0] {
    PET_ROT_ADJUST,
    PET_ROT_NEXT_SPEED,
    PET_ROT_CALC_TIME,
    PET_ROT_ODOMETER,
    PET_ROT_OTHER
  } pet_rot_t;
  // Auxiliary display source.
  typedef enum logic [1:0] {
    PET_AUX_NORMAL,
    PET_AUX_ERROR,
    PET_AUX_AUX_CALC
  } pet_aux_t;
endpackage

// file: pet_sync.sv
// Two-flop synchroniser with a stable-level debounce for a front-panel switch.
// Assumes the switch is asynchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module pet_sync #(
  parameter int unsigned DEB = pet_pkg::DEB_CYCLES
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Switch level in and debounced level out.
  input  wire logic sw_in,
  output logic      sw_out
);
  logic        s1_ff;
  logic        s2_ff;
  logic [19:0] cnt_ff;
  wire         same = (s2_ff == sw_out);

  // Synchronise, then accept a new level after it has stood for DEB cycles.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff  <= 1'b0;
      s2_ff  <= 1'b0;
      cnt_ff <= 20'h0_0000;
      sw_out <= 1'b0;
    end else begin
      s1_ff <= sw_in;
      s2_ff <= s1_ff;
      if (same) begin
        cnt_ff <= 20'h0_0000;
      end else if (cnt_ff >= 20'(DEB - 1)) begin
        cnt_ff <= 20'h0_0000;
        sw_out <= s2_ff;
      end else begin
        cnt_ff <= cnt_ff + 20'h0_0001;
      end
    end
  end
endmodule
`default_nettype wire

// file: pet_cnt.sv
// Twelve-hour tenth-second counter with clear, hold-at-zero and wrap.
// Assumes tick is a one-cycle enable on clk, from the owner's divider or from another same-clock source.
`timescale 1ns/1ps
`default_nettype none
module pet_cnt #(
  parameter int unsigned WRAP = pet_pkg::TWELVE_H_TICKS
) (
  // Clock and reset.
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Control.
  input  wire logic                     tick,
  input  wire logic                     run,
  input  wire logic                     clear,
  // Count.
  output logic [pet_pkg::CNT_W-1:0]     count
);
  // Clear holds zero; otherwise count on each tick while run is set and wrap at twelve hours.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (tick && run) begin
      count <= (count >= pet_pkg::CNT_W'(WRAP - 1)) ? '0 : count + 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: pet_props.sv
// Checker for pet_top: timing relations between its ports.
// Assumes a bind onto pet_top; reset_n is its asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module pet_props #(
  parameter int ODO_W = 20
) (
  // Clock, reset and mode input.
  input wire logic               ref_clk,
  input wire logic               reset_n,
  input wire logic               hundredths_mode,
  // Observed outputs.
  input wire logic               practice_mode,
  input wire logic               show_zero_hour,
  input wire logic               max_alt_format,
  input wire logic [18:0]        event_timer,
  input wire logic [18:0]        calc_counter,
  input wire logic [ODO_W-1:0]   odometer,
  input wire logic [18:0]        err_live,
  input wire logic [18:0]        aux_err,
  input wire logic [1:0]         aux_src,
  input wire logic               split_held,
  input wire logic [ODO_W-1:0]   split_dist,
  input wire logic [18:0]        split_perfect
);
  localparam int unsigned TW = pet_pkg::TWELVE_H_TICKS;
  // Magnitude of the gap between the two counters.
  logic [18:0] diff_w;
  assign diff_w = (event_timer > calc_counter) ? event_timer - calc_counter
                                               : calc_counter - event_timer;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  AST_MODE_STANDS: assert property ($past(practice_mode) |-> practice_mode)
    else $error("practice mode changed after power-up");
  AST_ALT_FMT: assert property ($stable(hundredths_mode) && $stable(practice_mode) |->
    max_alt_format == (practice_mode && hundredths_mode)) else $error("alt format wrong");
  AST_IDLE_ZERO: assert property (!practice_mode |-> event_timer == '0 && calc_counter == '0)
    else $error("counter moved with practice off");
  AST_ZERO_HOUR: assert property (show_zero_hour == $past(practice_mode))
    else $error("zero hour flag wrong");
  AST_ERR_MAG: assert property (event_timer == $past(event_timer, 2) &&
    calc_counter == $past(calc_counter, 2) |-> err_live == diff_w) else $error("error size wrong");
  AST_FREEZE: assert property (split_held && $past(split_held) |-> $stable(aux_err))
    else $error("aux error moved while split");
  AST_NO_AUX_CALC: assert property (practice_mode |-> aux_src != 2'h2)
    else $error("aux calc time shown in practice");
  AST_OFF_ROUTE: assert property (!practice_mode && aux_src == 2'h1 |->
    split_held || $past(split_held)) else $error("error shown unsplit");
  AST_CAPTURE: assert property ($rose(split_held) |-> split_perfect == calc_counter &&
    split_dist == odometer) else $error("split capture wrong");
  AST_BELOW_WRAP: assert property (event_timer < TW && calc_counter < TW)
    else $error("counter beyond twelve hours");
  // Main scenarios reached.
  cover property ($rose(practice_mode));
  cover property ($rose(split_held));
  cover property (aux_src == 2'h1);
endmodule
`default_nettype wire

// file: pet_panel.sv
// Front panel model: toggle and rotary switch contacts.
// Assumes the bench commands positions; contacts settle off the clock.
`timescale 1ns/1ps
`default_nettype none
module pet_panel (
  // Commanded positions: shift, minus, reset, split, time, rotary.
  input  wire logic [7:0] cmd,
  // Switch contacts.
  output logic            shift_sw,
  output logic            ones_minus_sw,
  output logic            reset_sw,
  output logic            split_sw,
  output logic            time_sel_sw,
  output logic [2:0]      rotary_sw
);
  // Contacts follow the command with a delay unrelated to the clock.
  assign #7 {shift_sw, ones_minus_sw, reset_sw, split_sw, time_sel_sw, rotary_sw} = cmd;
endmodule
`default_nettype wire

// file: test_practice_error_timer.sv
// Testbench for pet_top: mode toggle, counters, error routing, split.
// Assumes pet_panel and pet_props are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module test_practice_error_timer;
  // Stimulus and bookkeeping.
  logic ref_clk = 1'b0, reset_n = 1'b0, power_up = 1'b0, practice_saved = 1'b0;
  logic calc_tick = 1'b0, odo_pulse = 1'b0, hundredths_mode = 1'b0, rnd_on = 1'b0;
  logic [7:0] cmd = 8'h00;
  int fails = 0, n_compared = 0, n_calc = 0, n_odo = 0, sp;
  // Wires between panel, design and checker.
  logic shift_sw, ones_minus_sw, reset_sw, split_sw, time_sel_sw, practice_mode;
  logic show_zero_hour, max_alt_format, split_held, err_late;
  logic [2:0] rotary_sw;
  logic [1:0] aux_src;
  logic [18:0] event_timer, calc_counter, err_live, aux_err, split_elapsed, split_perfect;
  logic [19:0] odometer, split_dist;
  always #20 ref_clk = ~ref_clk;
  pet_panel panel (.cmd, .shift_sw, .ones_minus_sw, .reset_sw, .split_sw, .time_sel_sw,
    .rotary_sw);
  pet_top #(.TICK(10), .DEBOUNCE(2), .ODO_W(20)) dut (.ref_clk, .reset_n, .shift_sw,
    .ones_minus_sw, .reset_sw, .split_sw, .time_sel_sw, .rotary_sw, .power_up,
    .practice_saved, .calc_tick, .odo_pulse, .hundredths_mode, .practice_mode, .event_timer,
    .calc_counter, .odometer, .show_zero_hour, .max_alt_format, .err_late, .err_live,
    .aux_err, .aux_src, .split_held, .split_dist, .split_elapsed, .split_perfect);
  // Random calculated-time and odometer pulses, counted as sent.
  always @(posedge ref_clk) begin
    bit c, o;
    c = rnd_on && ($urandom % 3 == 0);
    o = rnd_on && ($urandom % 5 == 0);
    n_calc += c;
    n_odo += o;
    calc_tick <= c;
    odo_pulse <= o;
  end
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // Expected auxiliary source: 1 the error, 2 aux calc time, 0 normal.
  function automatic logic [1:0] exp_err(logic p, logic t, logic [2:0] r, logic s);
    if (p) return (t && r < 3'h4) ? 2'h1 : 2'h0;
    return (t && r == 3'h1 && s) ? 2'h1 : (t ? 2'h2 : 2'h0);
  endfunction
  // Magnitude of the gap between two tenth-second counts.
  function automatic logic [18:0] absd(logic [18:0] a, logic [18:0] b);
    return (a > b) ? a - b : b - a;
  endfunction
  // Power cycle with the toggle switches held or not; a late pulse is ignored.
  task automatic boot(logic saved, logic hold);
    reset_n <= 1'b0;
    practice_saved <= saved;
    cmd <= {hold, hold, 6'h00};
    cyc(12);
    reset_n <= 1'b1;
    cyc(10);
    power_up <= 1'b1;
    cyc(1);
    power_up <= 1'b0;
    cmd <= 8'h00;
    cyc(8);
    power_up <= 1'b1;
    cyc(1);
    power_up <= 1'b0;
    cyc(2);
  endtask
  task automatic press(logic [7:0] base);
    cmd <= base | 8'h10;
    cyc(8);
    cmd <= base;
    cyc(8);
  endtask
  task automatic pulses(int n);
    rnd_on <= 1'b1;
    cyc(n);
    rnd_on <= 1'b0;
    cyc(3);
  endtask
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    test_done();
  end
  initial begin
    void'($urandom(32'hB700));
    for (int i = 0; i < 4; i++) begin
      boot(i[0], i[1]);
      cmp("practice_mode", i[0] ^ i[1], practice_mode);
      cmp("show_zero_hour", i[0] ^ i[1], show_zero_hour);
    end
    $display("test boot toggle finished");
    boot(1'b0, 1'b1);
    pulses(150);
    cmp("calc_counter", n_calc, calc_counter);
    cmp("err_live", absd(event_timer, calc_counter), err_live);
    cmp("err_late", event_timer > calc_counter, err_late);
    hundredths_mode <= 1'b1;
    cyc(3);
    cmp("max_alt_format", 1, max_alt_format);
    hundredths_mode <= 1'b0;
    press(8'h09);
    cmp("split_held", 1, split_held);
    cmp("split_perfect", n_calc, split_perfect);
    cmp("split_dist", n_odo, split_dist);
    sp = n_calc;
    pulses(60);
    cmp("calc_live", n_calc, calc_counter);
    cmp("split_stands", sp, split_perfect);
    cmp("aux_frozen", absd(split_elapsed, split_perfect), aux_err);
    press(8'h09);
    cmp("split_released", 0, split_held);
    cmp("aux_live", absd(event_timer, calc_counter), aux_err);
    $display("test split finished");
    cmd <= 8'h29;
    pulses(60);
    cmp("timer_held", 0, event_timer);
    cmp("calc_held", 0, calc_counter);
    cmp("odo_held", 0, odometer);
    cmp("err_held", 0, err_live);
    cmd <= 8'h09;
    cyc(6);
    n_calc = 0;
    pulses(200);
    cmp("calc_after_release", n_calc, calc_counter);
    cmp("timer_runs", 1, event_timer >= 19'h12 && event_timer <= 19'h16);
    $display("test reset hold finished");
    for (int j = 0; j < 16; j++) begin
      cmd <= {4'h0, j[3], j[2:0]};
      cyc(8);
      cmp("error_routed", exp_err(1'b1, j[3], j[2:0], 1'b0), aux_src);
    end
    boot(1'b0, 1'b0);
    for (int j = 0; j < 32; j++) begin
      if (j == 16) press(8'h00);
      cmd <= {4'h0, j[3], 3'($urandom % 8)};
      cyc(8);
      cmp("error_off", exp_err(1'b0, j[3], rotary_sw, j[4]), aux_src);
    end
    pulses(40);
    cmp("calc_idle", 0, calc_counter);
    $display("test routing finished");
    test_done();
  end
endmodule
bind pet_top pet_props #(.ODO_W(ODO_W)) u_props (.ref_clk, .reset_n, .hundredths_mode,
  .practice_mode, .show_zero_hour, .max_alt_format, .event_timer, .calc_counter, .odometer,
  .err_live, .aux_err, .aux_src, .split_held, .split_dist, .split_perfect);
`default_nettype wire
